// [apc_bus_if.sv]
// io port bus joining host processor end and attribute controller end
`timescale 1ns/1ps
`default_nettype none

interface apc_bus_if;
	import apc_pkg::*;

	apc_port_t io_addr;
	apc_byte_t io_wdata;
	logic      io_wr;
	logic      io_rd;
	apc_byte_t io_rdata;

	modport host (
		output io_addr,
		output io_wdata,
		output io_wr,
		output io_rd,
		input  io_rdata
	);

	modport device (
		input  io_addr,
		input  io_wdata,
		input  io_wr,
		input  io_rd,
		output io_rdata
	);

endinterface : apc_bus_if

`default_nettype wire

// [apc_checker.sv]
// assertions on the io port bus between host end and controller end
`timescale 1ns/1ps
`default_nettype none
`include "apc_consts.svh"

module apc_checker (
	input wire logic               clk_i,
	input wire logic               reset_i,
	input wire apc_pkg::apc_port_t io_addr,
	input wire apc_pkg::apc_byte_t io_wdata,
	input wire logic               io_wr,
	input wire logic               io_rd,
	input wire apc_pkg::apc_byte_t io_rdata
);
	import apc_pkg::*;

	logic iosel_reg;

	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);

	// follows the status port mapping that the host last programmed
	always_ff @(posedge clk_i) begin
		if (reset_i)
			iosel_reg <= 1'b0;
		else if (io_wr && io_addr == `APC_PORT_MISC)
			iosel_reg <= io_wdata[0];
	end

	sequence attr_wr_s;
		io_wr && io_addr == `APC_PORT_ATTR;
	endsequence

	sequence data_show_s;
		attr_wr_s ##1 attr_wr_s ##0 io_wdata == `APC_SHOW_INDEX;
	endsequence

	no_dual_strobe_a: assert property (!(io_wr && io_rd))
		else $error("write and read strobes together");
	rdata_idle_a: assert property (!io_rd |=> io_rdata == 8'h00)
		else $error("read data outside its slot");
	stat_layout_a: assert property (io_rd |=> (io_rdata & 8'hf6) == 8'h00)
		else $error("status byte has stray bits");
	wr_port_a: assert property (io_wr |-> io_addr == `APC_PORT_ATTR ||
		io_addr == `APC_PORT_MISC)
		else $error("write to an unexpected port");
	stat_port_a: assert property (io_rd |-> io_addr == (iosel_reg ?
		`APC_PORT_STAT_COLOR : `APC_PORT_STAT_MONO))
		else $error("status read at wrong port");
	resync_attr_a: assert property (io_rd |=> !io_wr ##[1:7]
		(io_rd || (io_wr && io_addr == `APC_PORT_ATTR)))
		else $error("status read not followed by port access");
	index_data_a: assert property (attr_wr_s ##0 !$past(io_wr) |=>
		data_show_s)
		else $error("index and data not followed by display index");
	rd_pulse_a: assert property (io_rd |=> !io_rd)
		else $error("read strobe longer than one cycle");
	reset_quiet_a: assert property ($fell(reset_i) |-> !io_wr && !io_rd)
		else $error("strobe right after reset");

endmodule : apc_checker

`default_nettype wire

// [apc_consts.svh]
// constants of the attribute palette controller and its host end
// ----------------------------------------------------------------------
// Overview of operation
// - six-bit index pointer at port 3C0
// - selector toggles on every attribute port access
// - status port read forces selector to index
// - index bit 5 picks palette address source
// - sixteen six-bit palette entries, indices 00-0F
// - palette bits map to the six colour outputs
// - host rewrites palette only during vertical retrace; apc_host waits for retrace only when config bit APC_CFG_WAITVR_BIT is set
// - mode control written only at index 10/30
// - mode bit 0 selects alphanumeric or graphics
// - mode bit 1 selects mono or colour attributes
// - mode bit 2 copies eighth dot for C0-DF
// - software clears bit 2 without line graphics
// - mode bit 3 selects blink or background intensity
// - unused mode and index bits do nothing
// - io select bit picks 3BA or 3DA status
// ----------------------------------------------------------------------
`ifndef APC_CONSTS_SVH
`define APC_CONSTS_SVH

// io port map
`define APC_PORT_ATTR        10'h3c0
`define APC_PORT_MISC        10'h3c2
`define APC_PORT_STAT_MONO   10'h3ba
`define APC_PORT_STAT_COLOR  10'h3da

// index pointer fields
`define APC_IDX_ADDR_MSB     4
`define APC_IDX_SRC_BIT      5
`define APC_IDX_PAL_TOP_BIT  4
`define APC_IDX_MODE         5'h10

// mode control fields
`define APC_MODE_GFX_BIT     0
`define APC_MODE_COLOR_BIT   1
`define APC_MODE_LGFX_BIT    2
`define APC_MODE_BLINK_BIT   3

// misc output and status fields
`define APC_MISC_IOSEL_BIT   0
`define APC_STAT_VRT_BIT     3
`define APC_STAT_BLANK_BIT   0

// line graphics character range c0..df by its top three bits
`define APC_LGFX_CODE_TOP    3'h6

// reset values
`define APC_RST_INDEX        6'h00
`define APC_RST_MODE         4'h0
`define APC_RST_PAL          6'h00
`define APC_RST_IOSEL        1'b0
`define APC_RST_BYTE         8'h00

// host command register offsets
`define APC_CMD_TARGET       2'h0
`define APC_CMD_DATA         2'h1
`define APC_CMD_CONFIG       2'h2
`define APC_CMD_STATUS       2'h3
`define APC_CFG_IOSEL_BIT    0
`define APC_CFG_WAITVR_BIT   1
`define APC_SHOW_INDEX       8'h20

`endif

// [apc_device.sv]
// attribute controller end: index port, palette, mode control, colour path
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "apc_consts.svh"

module apc_device #(
	parameter int PAL_DEPTH = 16
) (
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	apc_bus_if.device             bus,
	input  wire apc_pkg::apc_attr_t gfx_color_i,
	input  wire apc_pkg::apc_byte_t char_code_i,
	input  wire apc_pkg::apc_byte_t char_attr_i,
	input  wire logic             glyph_dot_i,
	input  wire logic             dot8_i,
	input  wire logic             ninth_col_i,
	input  wire logic             blink_phase_i,
	input  wire logic             vretrace_i,
	input  wire logic             blank_i,
	output apc_pkg::apc_color_t   color_o,
	output logic                  gfx_mode_o,
	output logic                  io_sel_o
);
	import apc_pkg::*;

	if (PAL_DEPTH != 16) begin : g_bad_depth
		$error("apc_device: PAL_DEPTH must be 16");
	end

	// ------------------------------------------------------------------
	// port decode
	// ------------------------------------------------------------------
	logic      attr_wr;
	logic      attr_acc;
	logic      misc_wr;
	logic      stat_rd;
	apc_port_t stat_port;

	apc_sel_t   sel_reg;
	logic [5:0] index_reg;
	logic [3:0] mode_reg;
	logic       io_sel_reg;
	apc_color_t pal_reg [PAL_DEPTH];

	// status port address follows the io select bit
	assign stat_port = io_sel_reg ? `APC_PORT_STAT_COLOR
	                              : `APC_PORT_STAT_MONO;
	assign attr_wr  = bus.io_wr && (bus.io_addr == `APC_PORT_ATTR);
	assign attr_acc = (bus.io_wr || bus.io_rd) &&
	                  (bus.io_addr == `APC_PORT_ATTR);
	assign misc_wr  = bus.io_wr && (bus.io_addr == `APC_PORT_MISC);
	assign stat_rd  = bus.io_rd && (bus.io_addr == stat_port);

	logic idx_wr;
	logic dat_wr;
	assign idx_wr = attr_wr && (sel_reg == APC_SEL_INDEX);
	assign dat_wr = attr_wr && (sel_reg == APC_SEL_DATA);

	// ------------------------------------------------------------------
	// index / data selector
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sel_reg <= APC_SEL_INDEX;
		end else if (stat_rd) begin
			sel_reg <= APC_SEL_INDEX;
		end else if (attr_acc) begin
			// every access flips the selector
			sel_reg <= (sel_reg == APC_SEL_INDEX) ? APC_SEL_DATA
			                                      : APC_SEL_INDEX;
		end
	end

	// ------------------------------------------------------------------
	// index pointer
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			index_reg <= `APC_RST_INDEX;
		end else if (idx_wr) begin
			// bits 6 and 7 are dropped
			index_reg <= bus.io_wdata[5:0];
		end
	end

	// ------------------------------------------------------------------
	// palette entries
	// ------------------------------------------------------------------
	logic pal_wr;
	// host loads only while the address source bit is clear
	assign pal_wr = dat_wr && !index_reg[`APC_IDX_SRC_BIT] &&
	                !index_reg[`APC_IDX_PAL_TOP_BIT];

	for (genvar e = 0; e < PAL_DEPTH; e++) begin : g_pal
		always_ff @(posedge clk_i) begin
			if (reset_i) begin
				pal_reg[e] <= `APC_RST_PAL;
			end else if (pal_wr && (index_reg[3:0] == 4'(e))) begin
				pal_reg[e] <= bus.io_wdata[5:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// mode control and io select
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			mode_reg <= `APC_RST_MODE;
		end else if (dat_wr &&
		             index_reg[`APC_IDX_ADDR_MSB:0] == `APC_IDX_MODE) begin
			// index 10 and 30 both land here; bits 4-7 dropped
			mode_reg <= bus.io_wdata[3:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			io_sel_reg <= `APC_RST_IOSEL;
		end else if (misc_wr) begin
			io_sel_reg <= bus.io_wdata[`APC_MISC_IOSEL_BIT];
		end
	end

	// ------------------------------------------------------------------
	// read data: status port only, the attribute port is write only
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			bus.io_rdata <= `APC_RST_BYTE;
		end else if (stat_rd) begin
			bus.io_rdata <= {4'h0, vretrace_i, 2'b00, blank_i};
		end else begin
			bus.io_rdata <= `APC_RST_BYTE;
		end
	end

	// ------------------------------------------------------------------
	// text dot selection
	// ------------------------------------------------------------------
	logic      lgfx_code;
	logic      text_dot;
	logic      blink_attr;
	logic      shown_dot;
	apc_attr_t fg_idx;
	apc_attr_t bg_idx;
	apc_attr_t mono_fg;
	apc_attr_t mono_bg;
	apc_attr_t text_idx;
	apc_attr_t pix_idx;

	assign lgfx_code = (char_code_i[7:5] == `APC_LGFX_CODE_TOP);

	always_comb begin
		text_dot = glyph_dot_i;
		if (ninth_col_i) begin
			// ninth column repeats the eighth only for line graphics
			if (mode_reg[`APC_MODE_LGFX_BIT] && lgfx_code) begin
				text_dot = dot8_i;
			end else begin
				text_dot = 1'b0;
			end
		end
	end

	// top attribute bit is blink or background intensity
	assign blink_attr = mode_reg[`APC_MODE_BLINK_BIT] &&
	                    char_attr_i[7];
	assign shown_dot  = text_dot && !(blink_attr && blink_phase_i);

	assign fg_idx = char_attr_i[3:0];
	assign bg_idx = mode_reg[`APC_MODE_BLINK_BIT] ?
	                {1'b0, char_attr_i[6:4]} : char_attr_i[7:4];

	// mono attributes: lit or dark, reverse video, intensity bit kept
	assign mono_fg = (char_attr_i[2:0] == 3'h0) ? 4'h0
	                 : {char_attr_i[3], 3'h7};
	assign mono_bg = (char_attr_i[6:4] == 3'h7) ?
	                 {bg_idx[3], 3'h7} : 4'h0;

	always_comb begin
		if (mode_reg[`APC_MODE_COLOR_BIT]) begin
			text_idx = shown_dot ? fg_idx : bg_idx;
		end else begin
			text_idx = shown_dot ? mono_fg : mono_bg;
		end
	end

	assign pix_idx = mode_reg[`APC_MODE_GFX_BIT] ? gfx_color_i
	                                             : text_idx;

	// ------------------------------------------------------------------
	// colour output
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			color_o <= `APC_RST_PAL;
		end else if (index_reg[`APC_IDX_SRC_BIT]) begin
			// bit0 b, 1 g, 2 r, 3 sec b/mono, 4 sec g/int, 5 sec r
			color_o <= pal_reg[pix_idx];
		end else begin
			color_o <= `APC_RST_PAL;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			gfx_mode_o <= 1'b0;
			io_sel_o   <= `APC_RST_IOSEL;
		end else begin
			gfx_mode_o <= mode_reg[`APC_MODE_GFX_BIT];
			io_sel_o   <= io_sel_reg;
		end
	end

endmodule : apc_device

`default_nettype wire

// [apc_host.sv]
// host processor end: turns command registers into attribute port cycles
`timescale 1ns/1ps
`default_nettype none
`include "apc_consts.svh"

module apc_host (
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	apc_bus_if.host               bus,
	input  wire logic [1:0]       cmd_addr_i,
	input  wire apc_pkg::apc_byte_t cmd_wdata_i,
	input  wire logic             cmd_wr_i,
	input  wire logic             cmd_rd_i,
	output apc_pkg::apc_byte_t    cmd_rdata_o
);
	import apc_pkg::*;

	apc_host_state_t state_reg;
	apc_byte_t       target_reg;
	apc_byte_t       data_reg;
	logic [1:0]      config_reg;
	apc_byte_t       stat_reg;
	logic            busy;

	assign busy = (state_reg != APC_H_IDLE);

	// ------------------------------------------------------------------
	// command registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			target_reg <= `APC_RST_BYTE;
			data_reg   <= `APC_RST_BYTE;
			config_reg <= 2'b00;
		end else if (cmd_wr_i && !busy) begin
			if (cmd_addr_i == `APC_CMD_TARGET) begin
				target_reg <= cmd_wdata_i;
			end else if (cmd_addr_i == `APC_CMD_DATA) begin
				data_reg <= cmd_wdata_i;
			end else if (cmd_addr_i == `APC_CMD_CONFIG) begin
				config_reg <= cmd_wdata_i[1:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			cmd_rdata_o <= `APC_RST_BYTE;
		end else if (cmd_rd_i) begin
			if (cmd_addr_i == `APC_CMD_TARGET) begin
				cmd_rdata_o <= target_reg;
			end else if (cmd_addr_i == `APC_CMD_DATA) begin
				cmd_rdata_o <= data_reg;
			end else if (cmd_addr_i == `APC_CMD_CONFIG) begin
				cmd_rdata_o <= {6'h00, config_reg};
			end else begin
				cmd_rdata_o <= {stat_reg[7:1], busy};
			end
		end else begin
			cmd_rdata_o <= `APC_RST_BYTE;
		end
	end

	// ------------------------------------------------------------------
	// port cycle sequencer
	// ------------------------------------------------------------------
	apc_port_t stat_port;
	assign stat_port = config_reg[`APC_CFG_IOSEL_BIT] ?
	                   `APC_PORT_STAT_COLOR : `APC_PORT_STAT_MONO;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_reg    <= APC_H_IDLE;
			stat_reg     <= `APC_RST_BYTE;
			bus.io_addr  <= 10'h000;
			bus.io_wdata <= `APC_RST_BYTE;
			bus.io_wr    <= 1'b0;
			bus.io_rd    <= 1'b0;
		end else begin
			bus.io_wr <= 1'b0;
			bus.io_rd <= 1'b0;
			case (state_reg)
			APC_H_IDLE: begin
				if (cmd_wr_i && cmd_addr_i == `APC_CMD_CONFIG) begin
					bus.io_addr  <= `APC_PORT_MISC;
					bus.io_wdata <= {7'h00, cmd_wdata_i[0]};
					bus.io_wr    <= 1'b1;
					state_reg    <= APC_H_MISC_WR;
				end else if (cmd_wr_i && cmd_addr_i == `APC_CMD_DATA) begin
					state_reg <= APC_H_SYNC_RD;
				end
			end
			APC_H_MISC_WR: begin
				state_reg <= APC_H_IDLE;
			end
			APC_H_SYNC_RD: begin
				// status read puts the selector back on index
				bus.io_addr <= stat_port;
				bus.io_rd   <= 1'b1;
				state_reg   <= APC_H_SYNC_WAIT;
			end
			APC_H_SYNC_WAIT: begin
				if (!bus.io_rd) begin
					stat_reg <= bus.io_rdata;
					if (config_reg[`APC_CFG_WAITVR_BIT] &&
					    !bus.io_rdata[`APC_STAT_VRT_BIT]) begin
						state_reg <= APC_H_SYNC_RD;
					end else begin
						bus.io_addr  <= `APC_PORT_ATTR;
						bus.io_wdata <= target_reg;
						bus.io_wr    <= 1'b1;
						state_reg    <= APC_H_IDX_WR;
					end
				end
			end
			APC_H_IDX_WR: begin
				bus.io_wdata <= data_reg;
				bus.io_wr    <= 1'b1;
				state_reg    <= APC_H_DATA_WR;
			end
			APC_H_DATA_WR: begin
				// give the palette back to the screen data
				bus.io_wdata <= `APC_SHOW_INDEX;
				bus.io_wr    <= 1'b1;
				state_reg    <= APC_H_SHOW_WR;
			end
			APC_H_SHOW_WR: begin
				state_reg <= APC_H_IDLE;
			end
			default: begin
				state_reg <= APC_H_IDLE;
			end
			endcase
		end
	end

endmodule : apc_host

`default_nettype wire

// [apc_pkg.sv]
// types shared by both ends of the attribute palette controller
package apc_pkg;

	typedef logic [9:0] apc_port_t;
	typedef logic [7:0] apc_byte_t;
	typedef logic [5:0] apc_color_t;
	typedef logic [3:0] apc_attr_t;

	typedef enum logic {
		APC_SEL_INDEX,
		APC_SEL_DATA
	} apc_sel_t;

	typedef enum logic [2:0] {
		APC_H_IDLE,
		APC_H_MISC_WR,
		APC_H_SYNC_RD,
		APC_H_SYNC_WAIT,
		APC_H_IDX_WR,
		APC_H_DATA_WR,
		APC_H_SHOW_WR
	} apc_host_state_t;

endpackage : apc_pkg

// [apc_tb_top.sv]
// self-checking bench: host commands drive the attribute controller
`timescale 1ns/1ps
`default_nettype none

module apc_tb_top;
	import apc_pkg::*;

	logic       clk_i, reset_i, cmd_wr_i, cmd_rd_i;
	logic [1:0] cmd_addr_i;
	apc_byte_t  cmd_wdata_i, cmd_rdata_o, char_code_i, char_attr_i, v;
	apc_attr_t  gfx_color_i;
	logic       glyph_dot_i, dot8_i, ninth_col_i, blink_phase_i;
	logic       vretrace_i, blank_i, gfx_mode_o, io_sel_o;
	apc_color_t color_o;
	int         miscompares = 0;
	int         compares = 0;

	apc_bus_if apc_bus_if_i ();
	apc_host apc_host_i (.clk_i, .reset_i, .bus(apc_bus_if_i), .cmd_addr_i,
		.cmd_wdata_i, .cmd_wr_i, .cmd_rd_i, .cmd_rdata_o);
	apc_device #(.PAL_DEPTH(16)) apc_device_i (.clk_i, .reset_i,
		.bus(apc_bus_if_i), .gfx_color_i, .char_code_i, .char_attr_i,
		.glyph_dot_i, .dot8_i, .ninth_col_i, .blink_phase_i, .vretrace_i,
		.blank_i, .color_o, .gfx_mode_o, .io_sel_o);
	apc_checker apc_checker_i (.clk_i, .reset_i,
		.io_addr(apc_bus_if_i.io_addr), .io_wdata(apc_bus_if_i.io_wdata),
		.io_wr(apc_bus_if_i.io_wr), .io_rd(apc_bus_if_i.io_rd),
		.io_rdata(apc_bus_if_i.io_rdata));

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic end_of_test();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test

	task automatic chk(input apc_byte_t got, input apc_byte_t exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic cmd_wr(input logic [1:0] a, input apc_byte_t d);
		@(posedge clk_i);
		cmd_addr_i  <= a;
		cmd_wdata_i <= d;
		cmd_wr_i    <= 1'b1;
		@(posedge clk_i);
		cmd_wr_i <= 1'b0;
	endtask : cmd_wr

	task automatic cmd_rd(input logic [1:0] a);
		@(posedge clk_i);
		cmd_addr_i <= a;
		cmd_rd_i   <= 1'b1;
		@(posedge clk_i);
		cmd_rd_i <= 1'b0;
		#1;
		v = cmd_rdata_o;
	endtask : cmd_rd

	// poll the busy flag, bounded
	task automatic wait_idle();
		int n;
		n = 0;
		@(posedge clk_i);
		do begin
			cmd_rd(2'h3);
			n++;
		end while (v[0] !== 1'b0 && n < 300);
		if (v[0] !== 1'b0)
			chk(8'h01, 8'h00);
	endtask : wait_idle

	task automatic reg_wr(input apc_byte_t idx, input apc_byte_t d);
		cmd_wr(2'h0, idx);
		cmd_wr(2'h1, d);
		wait_idle();
	endtask : reg_wr

	// dt is {blink phase, ninth column, eighth dot, glyph dot}
	task automatic vid(input apc_attr_t g, input apc_byte_t at,
		input apc_byte_t cd, input logic [3:0] dt, input apc_color_t e);
		@(posedge clk_i);
		gfx_color_i <= g;
		char_attr_i <= at;
		char_code_i <= cd;
		{blink_phase_i, ninth_col_i, dot8_i, glyph_dot_i} <= dt;
		repeat (3) @(posedge clk_i);
		#1;
		chk({2'b00, color_o}, {2'b00, e});
	endtask : vid

	function automatic apc_color_t pv(input int i);
		return apc_color_t'(i * 7 + 9);
	endfunction : pv

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		reset_i = 1'b1;
		vretrace_i = 1'b1;
		{cmd_addr_i, cmd_wdata_i, cmd_wr_i, cmd_rd_i} = '0;
		{gfx_color_i, char_code_i, char_attr_i, glyph_dot_i} = '0;
		{dot8_i, ninth_col_i, blink_phase_i, blank_i} = '0;
		repeat (12) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		#1;
		chk({gfx_mode_o, io_sel_o, color_o}, 8'h00);
		cmd_wr(2'h2, 8'h01);
		wait_idle();
		chk({7'h00, io_sel_o}, 8'h01);
		reg_wr(8'h10, 8'hf1);
		chk({7'h00, gfx_mode_o}, 8'h01);
		for (int i = 0; i < 16; i++)
			reg_wr(8'(i), 8'hc0 | {2'b00, pv(i)});
		for (int i = 0; i < 16; i++)
			vid(4'(i), 8'h00, 8'h00, 4'h0, pv(i));
		reg_wr(8'h25, 8'h3f);
		vid(4'h5, 8'h00, 8'h00, 4'h0, pv(5));
		reg_wr(8'h11, 8'h00);
		chk({7'h00, gfx_mode_o}, 8'h01);
		reg_wr(8'h30, 8'h00);
		chk({7'h00, gfx_mode_o}, 8'h00);
		reg_wr(8'hd0, 8'h01);
		chk({7'h00, gfx_mode_o}, 8'h01);
		reg_wr(8'h10, 8'h02);
		vid(4'h0, 8'h3a, 8'h41, 4'b0001, pv(10));
		vid(4'h0, 8'h3a, 8'h41, 4'b0000, pv(3));
		vid(4'h0, 8'h3a, 8'hc0, 4'b0110, pv(3));
		reg_wr(8'h10, 8'h06);
		vid(4'h0, 8'h3a, 8'hc0, 4'b0110, pv(10));
		vid(4'h0, 8'h3a, 8'hdf, 4'b0110, pv(10));
		vid(4'h0, 8'h3a, 8'he0, 4'b0110, pv(3));
		reg_wr(8'h10, 8'h0a);
		vid(4'h0, 8'hba, 8'h41, 4'b1001, pv(3));
		vid(4'h0, 8'hba, 8'h41, 4'b0001, pv(10));
		reg_wr(8'h10, 8'h02);
		vid(4'h0, 8'hba, 8'h41, 4'b0000, pv(11));
		reg_wr(8'h10, 8'h00);
		vid(4'h0, 8'h07, 8'h41, 4'b0001, pv(7));
		vid(4'h0, 8'h70, 8'h41, 4'b0000, pv(7));
		vid(4'h0, 8'h00, 8'h41, 4'b0001, pv(0));
		vretrace_i <= 1'b0;
		cmd_wr(2'h2, 8'h03);
		wait_idle();
		cmd_wr(2'h0, 8'h0f);
		cmd_wr(2'h1, 8'h3f);
		repeat (30) @(posedge clk_i);
		cmd_rd(2'h3);
		chk({7'h00, v[0]}, 8'h01);
		vretrace_i <= 1'b1;
		wait_idle();
		cmd_rd(2'h3);
		chk(v, 8'h08);
		// back to the mono status port: resync must now use the other address
		cmd_wr(2'h2, 8'h00);
		wait_idle();
		chk({7'h00, io_sel_o}, 8'h00);
		reg_wr(8'h10, 8'h00);
		chk({7'h00, gfx_mode_o}, 8'h00);
		reg_wr(8'h10, 8'h01);
		vid(4'hf, 8'h00, 8'h00, 4'h0, 6'h3f);
		end_of_test();
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		end_of_test();
	end

endmodule : apc_tb_top

`default_nettype wire
